//--- lcf_core.sv
// Purpose: apb register file, pin assignment and frame divider of the lcd core
// Assumes: lcd_clk_tick is a one-cycle pulse per lcd clock source period
// Notes:   zero wait state apb, pslverr on unmapped address
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module lcf_core #(
  parameter int SEGMENT_N = 32,
  parameter int PIX_WORDS = 4
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          lcd_clk_tick,
  output lcf_pkg::lcf_bias_t                 bias_config,
  output logic                               regulator_enable,
  output logic                               reference_enable,
  output logic                               pump_enable,
  output logic [1:0]                         regulator_clock_select,
  output lcf_pkg::lcf_shared_pins_t          shared_port_pins,
  output logic [SEGMENT_N-1:0]               segment_enable,
  output logic [3:0]                         common_active,
  output logic [1:0]                         common_slice,
  output logic                               frame_start,
  output logic [SEGMENT_N-1:0]               slice_pixels
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0]            ctrl_reg, ctrl_next;
  logic [3:0]            presc_reg, presc_next;
  logic [7:0]            regc_reg, regc_next;
  logic [SEGMENT_N-1:0]  segen_reg, segen_next;
  logic [31:0]           pix_reg [PIX_WORDS];
  logic [31:0]           pix_next [PIX_WORDS];
  logic [31:0]           prdata_next;
  logic                  pslverr_next;
  logic                  pready_reg;

  logic wr;
  logic rd;
  logic hit;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // ****************************************
  // frame divider state
  // ****************************************
  logic [1:0] mux_act_reg, mux_act_next;
  logic [3:0] presc_act_reg, presc_act_next;
  logic [3:0] pre_reg, pre_next;
  logic [1:0] phase_reg, phase_next;
  logic [1:0] slice_reg, slice_next;
  logic       fstart_reg, fstart_next;
  logic [1:0] phase_max;
  logic [1:0] slice_max;

  always_comb begin
    unique case (mux_act_reg)
      lcf_pkg::MUX_STATIC: phase_max = 2'h3;
      lcf_pkg::MUX_HALF:   phase_max = 2'h1;
      default:             phase_max = 2'h0;
    endcase
  end
  assign slice_max = mux_act_reg;

  always_comb begin
    mux_act_next = mux_act_reg;
    presc_act_next = presc_act_reg;
    pre_next     = pre_reg;
    phase_next   = phase_reg;
    slice_next   = slice_reg;
    fstart_next  = 1'b0;
    if (lcd_clk_tick) begin
      if (pre_reg == presc_act_reg) begin
        pre_next = 4'h0;
        if (phase_reg == phase_max) begin
          phase_next = 2'h0;
          if (slice_reg == slice_max) begin
            slice_next  = 2'h0;
            fstart_next = 1'b1;
            mux_act_next = ctrl_reg[lcf_pkg::MUX_LSB +: 2];
            presc_act_next = presc_reg;
          end else begin
            slice_next = slice_reg + 2'h1;
          end
        end else begin
          phase_next = phase_reg + 2'h1;
        end
      end else begin
        pre_next = pre_reg + 4'h1;
      end
    end
  end

  // ****************************************
  // register writes and reads
  // ****************************************
  always_comb begin
    ctrl_next  = ctrl_reg;
    presc_next = presc_reg;
    regc_next  = regc_reg;
    segen_next = segen_reg;
    for (int i = 0; i < PIX_WORDS; i++) begin
      pix_next[i] = pix_reg[i];
    end
    hit          = 1'b1;
    prdata_next  = 32'h0;
    unique case (paddr)
      lcf_pkg::OFS_CTRL:     prdata_next = {24'h0, ctrl_reg};
      lcf_pkg::OFS_PRESCALE: prdata_next = {28'h0, presc_reg};
      lcf_pkg::OFS_REG:      prdata_next = {24'h0, regc_reg};
      lcf_pkg::OFS_STATUS:   prdata_next = {16'h0, 2'h0, mux_act_reg, presc_act_reg,
                                            2'h0, slice_reg, 2'h0, bias_config};
      lcf_pkg::OFS_SEGEN:    prdata_next = 32'(segen_reg);
      default: begin
        hit = 1'b0;
        for (int i = 0; i < PIX_WORDS; i++) begin
          if (paddr == lcf_pkg::OFS_PIXEL + 12'(4 * i)) begin
            hit = 1'b1;
            prdata_next = pix_reg[i];
          end
        end
      end
    endcase
    if (wr && hit) begin
      unique case (paddr)
        lcf_pkg::OFS_CTRL:     ctrl_next = pwdata[7:0];
        lcf_pkg::OFS_PRESCALE: presc_next = pwdata[3:0];
        lcf_pkg::OFS_REG:      regc_next = pwdata[7:0] & lcf_pkg::REG_WMASK;
        lcf_pkg::OFS_STATUS:   ctrl_next = ctrl_reg;
        lcf_pkg::OFS_SEGEN:    segen_next = pwdata[SEGMENT_N-1:0];
        default: begin
          for (int i = 0; i < PIX_WORDS; i++) begin
            if (paddr == lcf_pkg::OFS_PIXEL + 12'(4 * i)) pix_next[i] = pwdata;
          end
        end
      endcase
    end
    pslverr_next = psel && !penable && !hit;
    if (!rd) prdata_next = 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= lcf_pkg::CTRL_RST;
      presc_reg   <= lcf_pkg::PRESC_RST;
      regc_reg    <= lcf_pkg::REG_RST;
      segen_reg   <= '0;
      for (int i = 0; i < PIX_WORDS; i++) begin
        pix_reg[i] <= 32'h0;
      end
      prdata      <= 32'h0;
      pslverr     <= 1'b0;
      pready_reg  <= 1'b0;
      mux_act_reg <= lcf_pkg::MUX_STATIC;
      presc_act_reg <= lcf_pkg::PRESC_RST;
      pre_reg     <= 4'h0;
      phase_reg   <= 2'h0;
      slice_reg   <= 2'h0;
      fstart_reg  <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      presc_reg   <= presc_next;
      regc_reg    <= regc_next;
      segen_reg   <= segen_next;
      for (int i = 0; i < PIX_WORDS; i++) begin
        pix_reg[i] <= pix_next[i];
      end
      prdata      <= prdata_next;
      pslverr     <= pslverr_next;
      pready_reg  <= psel && !penable;
      mux_act_reg <= mux_act_next;
      presc_act_reg <= presc_act_next;
      pre_reg     <= pre_next;
      phase_reg   <= phase_next;
      slice_reg   <= slice_next;
      fstart_reg  <= fstart_next;
    end
  end
  assign pready = pready_reg;

  // ****************************************
  // bias configuration and pins
  // ****************************************
  lcf_pkg::lcf_bias_t bias_next;
  logic [1:0]         reg_clk_sel;
  logic               pump;
  assign reg_clk_sel = regc_reg[lcf_pkg::REGCLK_LSB +: 2];
  assign pump  = regc_reg[lcf_pkg::PUMP_BIT];

  always_comb begin
    if (reg_clk_sel != lcf_pkg::REGCLK_OFF) begin
      bias_next = pump ? lcf_pkg::LCF_BIAS_REG_BOOST : lcf_pkg::LCF_BIAS_REG_PLAIN;
    end else if (pump) begin
      bias_next = lcf_pkg::LCF_LADDER_SOFT_CONTRAST;
    end else begin
      bias_next = lcf_pkg::LCF_LADDER_FIXED_CONTRAST;
    end
  end

  lcf_pkg::lcf_shared_pins_t pins_next;
  logic [1:0]                mux_sel;
  logic [SEGMENT_N-1:0]      slice_next_pix;
  logic [3:0]                com_act_next;
  assign mux_sel = ctrl_reg[lcf_pkg::MUX_LSB +: 2];

  for (genvar k = 0; k < 3; k++) begin : g_pin
    assign pins_next.com_drive[k]   = (mux_sel > 2'(k));
    assign pins_next.port_enable[k] = !(mux_sel > 2'(k));
  end

  for (genvar k = 0; k < 4; k++) begin : g_com
    assign com_act_next[k] = (mux_act_reg >= 2'(k));
  end

  always_comb begin
    slice_next_pix = '0;
    for (int s = 0; s < SEGMENT_N; s++) begin
      slice_next_pix[s] = pix_reg[slice_reg][s % 32] & segen_reg[s];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_config            <= lcf_pkg::LCF_LADDER_FIXED_CONTRAST;
      regulator_enable       <= 1'b0;
      reference_enable       <= 1'b0;
      pump_enable            <= 1'b0;
      regulator_clock_select <= 2'h0;
      shared_port_pins       <= '{com_drive: 3'h0, port_enable: 3'h7};
      segment_enable         <= '0;
      common_active          <= 4'h1;
      common_slice           <= 2'h0;
      frame_start            <= 1'b0;
      slice_pixels           <= '0;
    end else begin
      bias_config            <= bias_next;
      regulator_enable       <= (reg_clk_sel != lcf_pkg::REGCLK_OFF);
      reference_enable       <= (bias_next != lcf_pkg::LCF_LADDER_FIXED_CONTRAST);
      pump_enable            <= pump && (reg_clk_sel != lcf_pkg::REGCLK_OFF);
      regulator_clock_select <= reg_clk_sel;
      shared_port_pins       <= pins_next;
      segment_enable         <= segen_reg;
      common_active          <= com_act_next;
      common_slice           <= slice_reg;
      frame_start            <= fstart_reg;
      slice_pixels           <= slice_next_pix;
    end
  end
endmodule : lcf_core

//--- lcf_pkg.sv
// Purpose: constants and types for the lcd common/segment frame config core
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes:   register offsets chosen for this core
// Functional notes
// - both clock select bits and pump enable clear select fixed-contrast ladder
// - fixed-contrast ladder turns regulator and its reference fully off
// - clock select zero disables regulator; nonzero enables it with that clock
// - pump enable is regulator control bit 6; picks ladder type when disabled
// - four mux types: static, 1/2, 1/3, 1/4 using commons 0..3
// - common count select is display control bits 1:0
// - count select maps commons 1..3 onto the three shared pins
// - shared pin used as common loses port function and direction bit
// - common count select resets to zero, all shared pins digital
// - set segment enable bit makes its pin a segment driver
// - segment enables never override direction bits; software sets inputs
// - all segment enables clear after reset
// - each pixel bit maps to one unique common/segment pair
// - unused pixel bits remain ordinary read/write storage
// - static divides by 4x1x(p+1), 1/2 by 2x2x(p+1)
// - 1/3 divides by 1x3x(p+1), 1/4 by 1x4x(p+1)
package lcf_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_PRESCALE = 12'h004;
  localparam logic [11:0] OFS_REG      = 12'h008;
  localparam logic [11:0] OFS_STATUS   = 12'h00c;
  localparam logic [11:0] OFS_SEGEN    = 12'h010;
  localparam logic [11:0] OFS_PIXEL    = 12'h020;
  localparam int          MUX_LSB      = 0;
  localparam int          PUMP_BIT     = 6;
  localparam int          REGCLK_LSB   = 0;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [3:0]  PRESC_RST    = 4'h0;
  localparam logic [7:0]  REG_RST      = 8'h3c;
  localparam logic [7:0]  REG_WMASK    = 8'h7f;
  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0]  MUX_STATIC   = 2'h0;
  localparam logic [1:0]  MUX_HALF     = 2'h1;
  localparam logic [1:0]  MUX_THIRD    = 2'h2;
  localparam logic [1:0]  MUX_QUARTER  = 2'h3;
  localparam logic [1:0]  REGCLK_OFF   = 2'h0;

  typedef enum logic [1:0] {
    LCF_BIAS_REG_BOOST,
    LCF_BIAS_REG_PLAIN,
    LCF_LADDER_SOFT_CONTRAST,
    LCF_LADDER_FIXED_CONTRAST
  } lcf_bias_t;

  typedef struct packed {
    logic [2:0] com_drive;
    logic [2:0] port_enable;
  } lcf_shared_pins_t;
endpackage : lcf_pkg

//--- lcf_core_props.sv
// Purpose: port checker for lcf_core
// Assumes: zero wait state apb, registered outputs
// Notes:   bound to every lcf_core instance below
`timescale 1ns/1ps
module lcf_core_props #(
  parameter int SEGMENT_N = 32
) (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic [11:0]              paddr,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire lcf_pkg::lcf_bias_t       bias_config,
  input wire logic                     regulator_enable,
  input wire logic                     reference_enable,
  input wire logic                     pump_enable,
  input wire logic [1:0]               regulator_clock_select,
  input wire lcf_pkg::lcf_shared_pins_t shared_port_pins,
  input wire logic [3:0]               common_active,
  input wire logic [1:0]               common_slice,
  input wire logic                     frame_start
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  // address held through access, so decode it live
  assign mapped = paddr inside {lcf_pkg::OFS_CTRL, lcf_pkg::OFS_PRESCALE, lcf_pkg::OFS_REG,
                                lcf_pkg::OFS_STATUS, lcf_pkg::OFS_SEGEN, lcf_pkg::OFS_PIXEL,
                                lcf_pkg::OFS_PIXEL + 12'h004, lcf_pkg::OFS_PIXEL + 12'h008,
                                lcf_pkg::OFS_PIXEL + 12'h00c};
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("pready missing after setup");
  a_err_map: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong for address");
  a_ref_fixed:
    assert property (reference_enable == (bias_config != lcf_pkg::LCF_LADDER_FIXED_CONTRAST))
    else $error("reference on in fixed ladder");
  a_reg_clock:
    assert property (regulator_enable == (regulator_clock_select != 2'h0)) else $error("regulator enable mismatch");
  a_bias_kind:
    assert property (regulator_enable ==
                     (bias_config inside {lcf_pkg::LCF_BIAS_REG_BOOST, lcf_pkg::LCF_BIAS_REG_PLAIN}))
    else $error("bias kind vs regulator");
  a_pump_boost:
    assert property (pump_enable == (bias_config == lcf_pkg::LCF_BIAS_REG_BOOST)) else $error("pump vs boost");
  a_pins_split:
    assert property (shared_port_pins.port_enable == ~shared_port_pins.com_drive) else $error("pin shared twice");
  a_com_shape:
    assert property (common_active inside {4'h1, 4'h3, 4'h7, 4'hf} &&
                     shared_port_pins.com_drive inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("common map not contiguous");
  a_slice_act:
    assert property (common_active[common_slice]) else $error("slice on idle common");
  a_frame_pulse:
    assert property (frame_start |=> !frame_start) else $error("frame pulse too long");
  // mux may only move with the frame pulse, never mid frame
  a_com_frame:
    assert property ($changed(common_active) |-> frame_start) else $error("commons changed mid frame");
  a_slice_wrap:
    assert property (frame_start |-> common_slice == 2'h0) else $error("frame not started on common 0");
endmodule : lcf_core_props

bind lcf_core lcf_core_props #(.SEGMENT_N(SEGMENT_N)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .bias_config(bias_config),
  .regulator_enable(regulator_enable), .reference_enable(reference_enable), .pump_enable(pump_enable),
  .regulator_clock_select(regulator_clock_select), .shared_port_pins(shared_port_pins),
  .common_active(common_active), .common_slice(common_slice), .frame_start(frame_start));

//--- lcf_panel.sv
// Purpose: passive panel, measures frame length
// Assumes: one frame_start pulse per frame
// Notes:   period counted in pclk cycles
`timescale 1ns/1ps
module lcf_panel (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic frame_start,
  output int        frame_period
);
  int cnt;
  // ****************
  // frame meter
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt          <= 0;
      frame_period <= 0;
    end else if (frame_start) begin
      frame_period <= cnt + 1;
      cnt          <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : lcf_panel

//--- lcd_common_segment_frame_config_test.sv
// Purpose: self-checking bench for lcf_core
// Assumes: tick every cycle unless half_rate, so frame length is in pclk cycles
// Notes:   rows cover every mux mode and bias config
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); \
  end \
end
module lcd_common_segment_frame_config_test;
  typedef struct {
    logic [1:0]         mux;
    logic [3:0]         p;
    logic [7:0]         rv;
    lcf_pkg::lcf_bias_t b;
    logic [2:0]         com;
    int                 per;
  } lcf_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b1;
  logic half_rate = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, segen;
  logic pready, pslverr, rerr, regen, refen, pumpen, fstart;
  logic [1:0] rclk, slice;
  logic [3:0] comact;
  lcf_pkg::lcf_bias_t bias;
  lcf_pkg::lcf_shared_pins_t pins;
  logic [31:0] spix;
  int fails = 0, num_checks = 0, per;
  lcf_row_t rows[4] = '{'{2'h0, 4'h2, 8'h00, lcf_pkg::LCF_LADDER_FIXED_CONTRAST, 3'h0, 12},
    '{2'h1, 4'h1, 8'h40, lcf_pkg::LCF_LADDER_SOFT_CONTRAST, 3'h1, 8},
    '{2'h2, 4'h0, 8'h02, lcf_pkg::LCF_BIAS_REG_PLAIN, 3'h3, 3},
    '{2'h3, 4'h3, 8'h41, lcf_pkg::LCF_BIAS_REG_BOOST, 3'h7, 16}};
  lcf_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lcd_clk_tick(tick), .bias_config(bias),
    .regulator_enable(regen), .reference_enable(refen), .pump_enable(pumpen), .regulator_clock_select(rclk),
    .shared_port_pins(pins), .segment_enable(segen), .common_active(comact), .common_slice(slice),
    .frame_start(fstart), .slice_pixels(spix));
  lcf_panel u_panel (.pclk(pclk), .presetn(presetn), .frame_start(fstart), .frame_period(per));
  initial forever #20 pclk = ~pclk;
  // slower lcd clock source: tick on every other cycle, so idle cycles are exercised
  always @(posedge pclk) tick <= half_rate ? ~tick : 1'b1;
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // ****************
  // tests
  // ****************
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, lcf_pkg::OFS_CTRL, {30'h0, rows[i].mux});
      apb(1'b1, lcf_pkg::OFS_PRESCALE, {28'h0, rows[i].p});
      apb(1'b1, lcf_pkg::OFS_REG, {24'h0, rows[i].rv});
      repeat (80) @(posedge pclk);
      `CHK("bias", rows[i].b, bias)
      `CHK("refen", rows[i].b != lcf_pkg::LCF_LADDER_FIXED_CONTRAST, refen)
      `CHK("regen", rows[i].rv[1:0] != 2'h0, regen)
      `CHK("regclk", rows[i].rv[1:0], rclk)
      `CHK("pump", rows[i].b == lcf_pkg::LCF_BIAS_REG_BOOST, pumpen)
      `CHK("comdrv", rows[i].com, pins.com_drive)
      `CHK("portfn", ~rows[i].com, pins.port_enable)
      `CHK("period", rows[i].per, per)
      apb(1'b0, lcf_pkg::OFS_CTRL, 32'h0);
      `CHK("ctrl", {30'h0, rows[i].mux}, rdat)
      $display("row %0d done", i);
    end
    half_rate <= 1'b1;
    apb(1'b1, lcf_pkg::OFS_CTRL, 32'h2);
    apb(1'b1, lcf_pkg::OFS_PRESCALE, 32'h0);
    repeat (100) @(posedge pclk);
    `CHK("half rate period", 6, per)
    half_rate <= 1'b0;
    $display("tick rate test done");
    apb(1'b1, lcf_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, lcf_pkg::OFS_SEGEN, 32'h0000_00ff);
    apb(1'b1, lcf_pkg::OFS_PIXEL, 32'ha5a5_a5a5);
    apb(1'b1, lcf_pkg::OFS_PIXEL + 12'h00c, 32'hffff_0000);
    repeat (40) @(posedge pclk);
    `CHK("segen", 32'h0000_00ff, segen)
    `CHK("slice", 2'h0, slice)
    `CHK("slicepix", 32'h0000_00a5, spix)
    apb(1'b0, lcf_pkg::OFS_PIXEL + 12'h00c, 32'h0);
    `CHK("pixrd", 32'hffff_0000, rdat)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK("unmap err", 1'b1, rerr)
    `CHK("unmap data", 32'h0, rdat)
    $display("pixel test done");
    apb(1'b1, lcf_pkg::OFS_CTRL, 32'h3);
    repeat (60) @(posedge pclk);
    `CHK("pre com", 4'hf, comact)
    `CHK("pre pins", 3'h0, pins.port_enable)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("rst segen", 32'h0, segen)
    `CHK("rst pins", 3'h7, pins.port_enable)
    `CHK("rst com", 4'h1, comact)
    `CHK("rst bias", lcf_pkg::LCF_LADDER_FIXED_CONTRAST, bias)
    `CHK("rst refen", 1'b0, refen)
    apb(1'b0, lcf_pkg::OFS_CTRL, 32'h0);
    `CHK("rst ctrl", 32'h0, rdat)
    $display("reset test done");
    finish_test();
  end
endmodule : lcd_common_segment_frame_config_test
